/* src/lipc_pkg.sv */
// Operation
// - Sixteen-bit mask inverts matching input pairs.
// - Enable source: align A, align B, low, high.
// - Bit 3 reverses received word bit order.
// - Bit 2 exchanges the A and B paths.
// - Bit 1 selects folded or interleaved samples.
// - Bit 0 selects falling or rising capture edge.
// - Writing one to bit 7 resets crossing.
// - I select: pass, gated by enable, constant.
// - Q select: pass, gated by enable, constant.
// - Mode field selects times two, four, eight.
// - I constant held as low, high bytes.
// - Q constant held as low, high bytes.
package lipc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned LIPC_WORD_W = 16;
  localparam int unsigned LIPC_ADDR_W = 5;
  localparam int unsigned LIPC_SYNC_W = 2 * LIPC_WORD_W + 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] LIPC_OFS_INV_LO = 5'h08;
  localparam logic [4:0] LIPC_OFS_INV_HI = 5'h09;
  localparam logic [4:0] LIPC_OFS_CTL = 5'h0A;
  localparam logic [4:0] LIPC_OFS_MISC = 5'h0B;
  localparam logic [4:0] LIPC_OFS_ICONST_LO = 5'h0C;
  localparam logic [4:0] LIPC_OFS_ICONST_HI = 5'h0D;
  localparam logic [4:0] LIPC_OFS_QCONST_LO = 5'h0E;
  localparam logic [4:0] LIPC_OFS_QCONST_HI = 5'h0F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LIPC_RST_INV = 8'h00;
  localparam logic [7:0] LIPC_RST_CTL = 8'h00;
  localparam logic [7:0] LIPC_RST_MISC = 8'h00;
  localparam logic [7:0] LIPC_RST_CONST_LO = 8'h00;
  localparam logic [7:0] LIPC_RST_ICONST_HI = 8'h00;
  localparam logic [7:0] LIPC_RST_QCONST_HI = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned LIPC_CTL_PARITY = 7;
  localparam int unsigned LIPC_CTL_DESCR = 6;
  localparam int unsigned LIPC_CTL_ENSRC = 4;
  localparam int unsigned LIPC_CTL_REVERSE = 3;
  localparam int unsigned LIPC_CTL_SWAP = 2;
  localparam int unsigned LIPC_CTL_IQ = 1;
  localparam int unsigned LIPC_CTL_EDGE = 0;
  localparam int unsigned LIPC_MISC_SRST = 7;
  localparam int unsigned LIPC_MISC_ISEL = 4;
  localparam int unsigned LIPC_MISC_QSEL = 2;
  localparam int unsigned LIPC_MISC_MODE = 0;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LIPC_EN_ALIGN_A = 2'h0;
  localparam logic [1:0] LIPC_EN_ALIGN_B = 2'h1;
  localparam logic [1:0] LIPC_EN_HIGH = 2'h3;
  localparam logic [1:0] LIPC_SEL_PASS = 2'h0;
  localparam logic [1:0] LIPC_SEL_GATED = 2'h1;
  localparam logic [1:0] LIPC_MODE_X2 = 2'h0;
  localparam logic [1:0] LIPC_MODE_X4 = 2'h1;

  // Last count of the rate divider for each ratio.
  localparam logic [2:0] LIPC_DIV_X2_LAST = 3'h1;
  localparam logic [2:0] LIPC_DIV_X4_LAST = 3'h3;
  localparam logic [2:0] LIPC_DIV_X8_LAST = 3'h7;
  localparam logic [2:0] LIPC_DIV_ZERO = 3'h0;

endpackage

/* src/lipc_sync.sv */
`timescale 1ns/1ps
module lipc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // lipc_sync

/* src/lipc_top.sv */
`timescale 1ns/1ps
module lipc_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [lipc_pkg::LIPC_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Link from the data source
  input wire logic input_link_clock_i,
  input wire logic [lipc_pkg::LIPC_WORD_W-1:0] input_data_pairs_a_i,
  input wire logic [lipc_pkg::LIPC_WORD_W-1:0] input_data_pairs_b_i,
  input wire logic align_a_i,
  input wire logic align_b_i,
  // Samples towards processing
  output logic [lipc_pkg::LIPC_WORD_W-1:0] i_sample_o,
  output logic [lipc_pkg::LIPC_WORD_W-1:0] q_sample_o,
  output logic sample_strobe_o,
  output logic data_enable_o,
  // Enables for checking and descrambling logic
  output logic parity_check_enable_o,
  output logic descramble_enable_o
);
  import lipc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [LIPC_SYNC_W-1:0] sync_w;
  logic link_clk_s;
  logic align_a_s;
  logic align_b_s;
  logic [LIPC_WORD_W-1:0] pairs_a_s;
  logic [LIPC_WORD_W-1:0] pairs_b_s;
  logic link_clk_prev_q;
  logic link_rise;
  logic link_fall;
  logic capture;

  logic [7:0] inv_lo_q;
  logic [7:0] inv_hi_q;
  logic [7:0] ctl_q;
  logic [6:0] misc_q;
  logic [7:0] iconst_lo_q;
  logic [7:0] iconst_hi_q;
  logic [7:0] qconst_lo_q;
  logic [7:0] qconst_hi_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;

  logic wr_inv_lo;
  logic wr_inv_hi;
  logic wr_ctl;
  logic wr_misc;
  logic wr_iconst_lo;
  logic wr_iconst_hi;
  logic wr_qconst_lo;
  logic wr_qconst_hi;
  logic srst_d;
  logic srst_q;

  logic [LIPC_WORD_W-1:0] pair_mask;
  logic [LIPC_WORD_W-1:0] a_pol;
  logic [LIPC_WORD_W-1:0] b_pol;
  logic [LIPC_WORD_W-1:0] a_sw;
  logic [LIPC_WORD_W-1:0] b_sw;
  logic [LIPC_WORD_W-1:0] a_word;
  logic [LIPC_WORD_W-1:0] b_word;
  logic [1:0] en_src;
  logic [1:0] i_sel;
  logic [1:0] q_sel;
  logic [1:0] mode;
  logic data_en;
  logic iq_interleaved;
  logic phase_q;

  logic [LIPC_WORD_W-1:0] cap_i_q;
  logic [LIPC_WORD_W-1:0] cap_q_q;
  logic [LIPC_WORD_W-1:0] cross_i_q;
  logic [LIPC_WORD_W-1:0] cross_q_q;
  logic [LIPC_WORD_W-1:0] i_const;
  logic [LIPC_WORD_W-1:0] q_const;
  logic [LIPC_WORD_W-1:0] i_next;
  logic [LIPC_WORD_W-1:0] q_next;
  logic [LIPC_WORD_W-1:0] i_sample_q;
  logic [LIPC_WORD_W-1:0] q_sample_q;
  logic [2:0] div_q;
  logic [2:0] div_last;
  logic div_wrap;
  logic strobe_q;
  logic data_en_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Data, alignment and link clock share one synchroniser so they stay
  // aligned to each other; the link clock is slow enough for this.
  lipc_sync #(
    .W(LIPC_SYNC_W)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i({input_link_clock_i, align_a_i, align_b_i,
              input_data_pairs_a_i, input_data_pairs_b_i}),
    .sync_o(sync_w)
  );

  assign link_clk_s = sync_w[LIPC_SYNC_W-1];
  assign align_a_s = sync_w[LIPC_SYNC_W-2];
  assign align_b_s = sync_w[LIPC_SYNC_W-3];
  assign pairs_a_s = sync_w[2*LIPC_WORD_W-1:LIPC_WORD_W];
  assign pairs_b_s = sync_w[LIPC_WORD_W-1:0];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_clk_prev_q <= 1'b0;
    end else begin
      link_clk_prev_q <= link_clk_s;
    end
  end

  assign link_rise = link_clk_s & ~link_clk_prev_q;
  assign link_fall = ~link_clk_s & link_clk_prev_q;
  assign capture = ctl_q[LIPC_CTL_EDGE] ? link_rise : link_fall;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign wr_inv_lo = reg_wr_i && (reg_addr_i == LIPC_OFS_INV_LO);
  assign wr_inv_hi = reg_wr_i && (reg_addr_i == LIPC_OFS_INV_HI);
  assign wr_ctl = reg_wr_i && (reg_addr_i == LIPC_OFS_CTL);
  assign wr_misc = reg_wr_i && (reg_addr_i == LIPC_OFS_MISC);
  assign wr_iconst_lo = reg_wr_i && (reg_addr_i == LIPC_OFS_ICONST_LO);
  assign wr_iconst_hi = reg_wr_i && (reg_addr_i == LIPC_OFS_ICONST_HI);
  assign wr_qconst_lo = reg_wr_i && (reg_addr_i == LIPC_OFS_QCONST_LO);
  assign wr_qconst_hi = reg_wr_i && (reg_addr_i == LIPC_OFS_QCONST_HI);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      inv_lo_q <= LIPC_RST_INV;
      inv_hi_q <= LIPC_RST_INV;
    end else begin
      if (wr_inv_lo) inv_lo_q <= reg_wdata_i;
      if (wr_inv_hi) inv_hi_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_q <= LIPC_RST_CTL;
    end else if (wr_ctl) begin
      ctl_q <= reg_wdata_i;
    end
  end

  // The reset bit is not stored: it acts only on the write that sets it.
  assign srst_d = wr_misc && reg_wdata_i[LIPC_MISC_SRST];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      misc_q <= LIPC_RST_MISC[6:0];
      srst_q <= 1'b0;
    end else begin
      if (wr_misc) misc_q <= reg_wdata_i[6:0];
      srst_q <= srst_d;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      iconst_lo_q <= LIPC_RST_CONST_LO;
      iconst_hi_q <= LIPC_RST_ICONST_HI;
    end else begin
      if (wr_iconst_lo) iconst_lo_q <= reg_wdata_i;
      if (wr_iconst_hi) iconst_hi_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      qconst_lo_q <= LIPC_RST_CONST_LO;
      qconst_hi_q <= LIPC_RST_QCONST_HI;
    end else begin
      if (wr_qconst_lo) qconst_lo_q <= reg_wdata_i;
      if (wr_qconst_hi) qconst_hi_q <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  assign rd_mux =
    (reg_addr_i == LIPC_OFS_INV_LO) ? inv_lo_q :
    (reg_addr_i == LIPC_OFS_INV_HI) ? inv_hi_q :
    (reg_addr_i == LIPC_OFS_CTL) ? ctl_q :
    (reg_addr_i == LIPC_OFS_MISC) ? {1'b0, misc_q} :
    (reg_addr_i == LIPC_OFS_ICONST_LO) ? iconst_lo_q :
    (reg_addr_i == LIPC_OFS_ICONST_HI) ? iconst_hi_q :
    (reg_addr_i == LIPC_OFS_QCONST_LO) ? qconst_lo_q :
    (reg_addr_i == LIPC_OFS_QCONST_HI) ? qconst_hi_q : 8'h00;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Input steering
  // ----------------------------------------------------------------
  assign pair_mask = {inv_hi_q, inv_lo_q};
  assign a_pol = pairs_a_s ^ pair_mask;
  assign b_pol = pairs_b_s ^ pair_mask;
  assign a_sw = ctl_q[LIPC_CTL_SWAP] ? b_pol : a_pol;
  assign b_sw = ctl_q[LIPC_CTL_SWAP] ? a_pol : b_pol;
  assign a_word = ctl_q[LIPC_CTL_REVERSE] ? {<<{a_sw}} : a_sw;
  assign b_word = ctl_q[LIPC_CTL_REVERSE] ? {<<{b_sw}} : b_sw;
  assign iq_interleaved = ctl_q[LIPC_CTL_IQ];

  assign en_src = ctl_q[LIPC_CTL_ENSRC+1:LIPC_CTL_ENSRC];
  assign data_en = (en_src == LIPC_EN_ALIGN_A) ? align_a_s :
                   (en_src == LIPC_EN_ALIGN_B) ? align_b_s :
                   (en_src == LIPC_EN_HIGH);

  assign parity_check_enable_o = ctl_q[LIPC_CTL_PARITY];
  assign descramble_enable_o = ctl_q[LIPC_CTL_DESCR];

  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // Interleaved words arrive I first; the phase restarts whenever the
  // enable drops, so a source can realign without a software reset.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= 1'b0;
    end else if (srst_q || !data_en || !iq_interleaved) begin
      phase_q <= 1'b0;
    end else if (capture) begin
      phase_q <= ~phase_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_i_q <= '0;
    end else if (srst_q) begin
      cap_i_q <= '0;
    end else if (capture && !(iq_interleaved && phase_q)) begin
      cap_i_q <= a_word;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_q_q <= '0;
    end else if (srst_q) begin
      cap_q_q <= '0;
    end else if (capture && (!iq_interleaved || phase_q)) begin
      cap_q_q <= iq_interleaved ? a_word : b_word;
    end
  end

  // ----------------------------------------------------------------
  // Crossing stage
  // ----------------------------------------------------------------
  // The unused mode code runs as times eight rather than stalling.
  assign mode = misc_q[LIPC_MISC_MODE+1:LIPC_MISC_MODE];
  assign div_last = (mode == LIPC_MODE_X2) ? LIPC_DIV_X2_LAST :
                    (mode == LIPC_MODE_X4) ? LIPC_DIV_X4_LAST :
                    LIPC_DIV_X8_LAST;
  assign div_wrap = (div_q >= div_last);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= LIPC_DIV_ZERO;
      strobe_q <= 1'b0;
    end else if (srst_q) begin
      div_q <= LIPC_DIV_ZERO;
      strobe_q <= 1'b0;
    end else begin
      div_q <= div_wrap ? LIPC_DIV_ZERO : div_q + 3'h1;
      strobe_q <= div_wrap;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cross_i_q <= '0;
      cross_q_q <= '0;
    end else if (srst_q) begin
      cross_i_q <= '0;
      cross_q_q <= '0;
    end else if (div_wrap) begin
      cross_i_q <= cap_i_q;
      cross_q_q <= cap_q_q;
    end
  end

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  assign i_sel = misc_q[LIPC_MISC_ISEL+1:LIPC_MISC_ISEL];
  assign q_sel = misc_q[LIPC_MISC_QSEL+1:LIPC_MISC_QSEL];
  assign i_const = {iconst_hi_q, iconst_lo_q};
  assign q_const = {qconst_hi_q, qconst_lo_q};
  assign i_next = (i_sel == LIPC_SEL_PASS) ? cross_i_q :
                  (i_sel == LIPC_SEL_GATED && data_en) ? cross_i_q : i_const;
  assign q_next = (q_sel == LIPC_SEL_PASS) ? cross_q_q :
                  (q_sel == LIPC_SEL_GATED && data_en) ? cross_q_q : q_const;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      i_sample_q <= '0;
      q_sample_q <= '0;
      data_en_q <= 1'b0;
    end else begin
      i_sample_q <= i_next;
      q_sample_q <= q_next;
      data_en_q <= data_en;
    end
  end

  assign i_sample_o = i_sample_q;
  assign q_sample_o = q_sample_q;
  assign sample_strobe_o = strobe_q;
  assign data_enable_o = data_en_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_pair_invert: assert property (
    (capture && !srst_q && !iq_interleaved && !ctl_q[LIPC_CTL_SWAP]
     && !ctl_q[LIPC_CTL_REVERSE]) |=> cap_i_q == $past(pairs_a_s ^ pair_mask))
    else $error("inverted pair capture mismatch");

  a_enable_forced: assert property (
    (en_src[1] && !wr_ctl) |=> data_enable_o == $past(en_src[0]) [*2])
    else $error("forced enable level wrong");

  a_bit_reverse: assert property (
    (capture && !srst_q && !iq_interleaved && ctl_q[LIPC_CTL_REVERSE]
     && !ctl_q[LIPC_CTL_SWAP]) |=> cap_i_q == {<<{$past(a_pol)}})
    else $error("reversed word mismatch");

  a_path_swap: assert property (
    (capture && !srst_q && !iq_interleaved && ctl_q[LIPC_CTL_SWAP]
     && !ctl_q[LIPC_CTL_REVERSE]) |=> cap_i_q == $past(b_pol))
    else $error("swapped path mismatch");

  a_interleave_q: assert property (
    (capture && !srst_q && iq_interleaved && phase_q)
      |=> cap_q_q == $past(a_word) && $stable(cap_i_q))
    else $error("interleaved Q word mismatch");

  a_edge_ignore: assert property (
    (link_rise && !ctl_q[LIPC_CTL_EDGE] && !srst_q)
      |=> $stable(cap_i_q) && $stable(cap_q_q))
    else $error("capture on unselected edge");

  a_soft_reset: assert property (
    srst_d |=> srst_q ##1 (cap_i_q == '0 && div_q == LIPC_DIV_ZERO && !strobe_q))
    else $error("soft reset did not clear crossing");

  a_i_constant: assert property (
    (i_sel[1] || (i_sel == LIPC_SEL_GATED && !data_en))
      |=> i_sample_o == $past(i_const))
    else $error("I constant not substituted");

  a_q_constant: assert property (
    (q_sel[1] || (q_sel == LIPC_SEL_GATED && !data_en))
      |=> q_sample_o == $past(q_const))
    else $error("Q constant not substituted");

  // The mode must stay put over the whole period, so later writes are excluded.
  a_rate_x4: assert property (
    (strobe_q && mode == LIPC_MODE_X4 && !wr_misc && !srst_q) ##1 !wr_misc [*2]
      |-> !$past(strobe_q) && !strobe_q ##1 !strobe_q ##1 strobe_q)
    else $error("times four strobe spacing wrong");

  a_iconst_high: assert property (
    wr_iconst_hi |=> i_const[15:8] == $past(reg_wdata_i))
    else $error("I constant high byte not stored");

  a_qconst_low: assert property (
    wr_qconst_lo |=> q_const[7:0] == $past(reg_wdata_i))
    else $error("Q constant low byte not stored");

  a_parity_enable: assert property (
    wr_ctl |=> parity_check_enable_o == $past(reg_wdata_i[LIPC_CTL_PARITY]))
    else $error("parity enable not taken from control");

  c_interleaved_pair: cover property (
    capture && iq_interleaved && phase_q ##1 strobe_q);
  c_soft_reset: cover property (srst_q);
  c_gated_constant: cover property (i_sel == LIPC_SEL_GATED && !data_en);
  c_swap_reverse: cover property (
    capture && ctl_q[LIPC_CTL_SWAP] && ctl_q[LIPC_CTL_REVERSE]);

endmodule // lipc_top

/* testbench/lipc_source.sv */
`timescale 1ns/1ps
module lipc_source (
  // Words and alignment levels chosen by the bench
  input wire logic [15:0] word_a_i,
  input wire logic [15:0] word_b_i,
  input wire logic align_a_i,
  input wire logic align_b_i,
  input wire logic iq_mode_i,
  // Link towards the device
  output logic link_clk_o,
  output logic [15:0] data_a_o,
  output logic [15:0] data_b_o,
  output logic align_a_o,
  output logic align_b_o
);
  // ------------------------------------------------------------
  // Link clock, 400 ns period, streaming continuously
  // ------------------------------------------------------------
  initial begin
    link_clk_o = 1'b0;
    forever #200 link_clk_o = ~link_clk_o;
  end

  // ------------------------------------------------------------
  // Data lines
  // ------------------------------------------------------------
  // Folded delivery: channel A carries I and channel B carries Q.
  // Interleaved delivery: channel A carries I then Q, each word launched on a
  // falling edge so it stands still around the rising edge; alignment on A
  // rises with the first I word so the device starts its phase there.
  logic run_q = 1'b0;
  logic phase_q = 1'b0;

  always @(negedge link_clk_o) begin
    run_q <= iq_mode_i;
    phase_q <= (iq_mode_i && run_q) ? ~phase_q : 1'b0;
  end

  assign data_a_o = (run_q && phase_q) ? word_b_i : word_a_i;
  assign data_b_o = word_b_i;
  assign align_a_o = iq_mode_i ? (run_q && align_a_i) : align_a_i;
  assign align_b_o = align_b_i;
endmodule // lipc_source

/* testbench/lipc_top_tb_top.sv */
`timescale 1ns/1ps
module lipc_top_tb_top;
  import lipc_pkg::*;
  logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, link_clk, al_a, al_b, strobe, den, par_en, des_en;
  logic wal_a, wal_b, iq;
  logic [LIPC_ADDR_W-1:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, d, c;
  logic [15:0] da, db, i_s, q_s, wa, wb, mask, ic, qc, wo;
  int errors, cmp_count, seed, n;

  lipc_source src (.word_a_i(wa), .word_b_i(wb), .align_a_i(wal_a), .align_b_i(wal_b),
    .iq_mode_i(iq),
    .link_clk_o(link_clk), .data_a_o(da), .data_b_o(db), .align_a_o(al_a), .align_b_o(al_b));

  lipc_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .input_link_clock_i(link_clk), .input_data_pairs_a_i(da),
    .input_data_pairs_b_i(db), .align_a_i(al_a), .align_b_i(al_b), .i_sample_o(i_s),
    .q_sample_o(q_s), .sample_strobe_o(strobe), .data_enable_o(den),
    .parity_check_enable_o(par_en), .descramble_enable_o(des_en));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data is registered on the edge that takes the strobe.
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask

  // A strobe is looked for one step after each edge so its launch has landed.
  task automatic wait_strobe(output int k);
    k = 0;
    do begin
      tick(1);
      k++;
    end while (strobe !== 1'b1 && k < 40);
  endtask

  function automatic logic [15:0] path(input logic [15:0] w, input logic [15:0] m,
                                       input logic r);
    logic [15:0] x;
    x = w ^ m;
    for (int k = 0; k < 16; k++) path[k] = r ? x[15-k] : x[k];
  endfunction

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h831217CE;
    errors = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 5'h00;
    reg_wdata_i = 8'h00;
    wa = 16'h1234;
    wb = 16'h5678;
    wal_a = 1'b1;
    wal_b = 1'b0;
    iq = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int a = 8; a < 16; a++) begin
      rd(a[4:0], d);
      chk(d, (a == 15) ? 16'h0080 : 16'h0000);
    end
    rd(5'h00, d);
    chk(d, 16'h0000);
    for (int a = 8; a < 16; a++) begin
      if (a != 10 && a != 11) begin
        c = $random(seed);
        wr(a[4:0], c);
        rd(a[4:0], d);
        chk(d, c);
      end
    end
    wr(LIPC_OFS_CTL, 8'hC0);
    tick(2);
    chk({par_en, des_en}, 16'h0003);
    wr(LIPC_OFS_MISC, 8'hB5);
    rd(LIPC_OFS_MISC, d);
    chk(d, 16'h0035);
    for (int e = 0; e < 4; e++) begin
      wr(LIPC_OFS_CTL, 8'(e << 4));
      tick(8);
      chk(den, (e == 0 || e == 3) ? 16'h0001 : 16'h0000);
    end
    // Mode code 11 must not be programmed, so only the three ratios are run.
    for (int m = 0; m < 3; m++) begin
      wr(LIPC_OFS_MISC, 8'(m));
      wait_strobe(n);
      wait_strobe(n);
      chk(16'(n), 16'(2 << m));
    end
    wr(LIPC_OFS_MISC, 8'h00);
    for (int it = 0; it < 8; it++) begin
      @(posedge ref_clk_i);
      wa <= $random(seed);
      wb <= $random(seed);
      mask = $random(seed);
      c = ($random(seed) & 8'h0D) | 8'h30;
      if (it < 2) c = {4'h3, 2'(it * 3), 2'(it)};
      wr(LIPC_OFS_INV_LO, mask[7:0]);
      wr(LIPC_OFS_INV_HI, mask[15:8]);
      wr(LIPC_OFS_CTL, c);
      tick(60);
      chk(i_s, path(c[2] ? wb : wa, mask, c[3]));
      chk(q_s, path(c[2] ? wa : wb, mask, c[3]));
    end
    // A word changed between a rising and a falling link edge shows which edge is taken.
    wr(LIPC_OFS_CTL, 8'h31);
    tick(20);
    wo = wa;
    @(posedge link_clk);
    repeat (2) @(posedge ref_clk_i);
    wa <= ~wo;
    tick(8);
    chk(i_s, wo ^ mask);
    tick(20);
    chk(i_s, ~wo ^ mask);
    // Interleaved delivery on channel A, enable from its alignment level.
    @(posedge ref_clk_i);
    wal_a <= 1'b0;
    wr(LIPC_OFS_CTL, 8'h03);
    tick(20);
    @(posedge ref_clk_i);
    iq <= 1'b1;
    wal_a <= 1'b1;
    tick(60);
    chk(i_s, wa ^ mask);
    chk(q_s, wb ^ mask);
    @(posedge ref_clk_i);
    iq <= 1'b0;
    ic = $random(seed);
    qc = $random(seed);
    wr(LIPC_OFS_ICONST_LO, ic[7:0]);
    wr(LIPC_OFS_ICONST_HI, ic[15:8]);
    wr(LIPC_OFS_QCONST_LO, qc[7:0]);
    wr(LIPC_OFS_QCONST_HI, qc[15:8]);
    for (int e = 2; e < 4; e++) begin
      for (int s = 0; s < 4; s++) begin
        wr(LIPC_OFS_CTL, 8'(e << 4));
        wr(LIPC_OFS_MISC, 8'((s << 4) | (s << 2)));
        tick(30);
        chk(i_s, (s >= 2 || (s == 1 && e == 2)) ? ic : (wa ^ mask));
        chk(q_s, (s >= 2 || (s == 1 && e == 2)) ? qc : (wb ^ mask));
      end
    end
    wr(LIPC_OFS_MISC, 8'h80);
    tick(2);
    chk(i_s, 16'h0000);
    complete_run();
  end

  // A hung handshake would otherwise stall the run forever.
  initial begin
    #(50 * 20000);
    errors++;
    complete_run();
  end
endmodule // lipc_top_tb_top
